// ===== hdl/relay_consts.svh
// constants for the relay decision block
// assumes a 50 MHz pclk and a 32-bit apb master
`ifndef RELAY_CONSTS_SVH
`define RELAY_CONSTS_SVH
// ==========================================
// register byte offsets
`define OFF_CTRL     8'h00
`define OFF_FS_TIMER 8'h04
`define OFF_STATUS   8'h08
`define OFF_SPAN     8'h0C
`define OFF_RLY_BASE 8'h20
`define RLY_STRIDE   8'h10
`define RLY_CFG      4'h0
`define RLY_ON       4'h4
`define RLY_OFF      4'h8
// ==========================================
// ctrl field positions
`define CTRL_PROG    0
`define CTRL_FSL_LO  1
`define CTRL_TEST_EN 3
`define CTRL_TSEL_LO 4
// relay cfg field positions
`define CFG_INV      4
`define CFG_FSA_LO   5
// ==========================================
// reset values and sizes
`define NUM_RELAYS   6
`define FS_MS_RST    16'h0064
`define SPAN_RST     16'h03E8
`define HYS_PCT      17'sd2
// ==========================================
// timing
`define CLK_NS       20
`define MS_NS        1000000
`define MS_CYC       (`MS_NS / `CLK_NS)
`define PULSE_MS     16'h00C8
`endif

// ===== hdl/relay_pkg.sv
// types for the relay decision block
// assumes relay_consts.svh is included by the user of these types
package relay_pkg;
    // ==========================================
    // relay function codes
    typedef enum logic [3:0] {
        FN_OFF   = 4'h0,
        FN_LVL   = 4'h1,
        FN_INB   = 4'h2,
        FN_OOB   = 4'h3,
        FN_RATE  = 4'h4,
        FN_TEMP  = 4'h5,
        FN_LOE   = 4'h6,
        FN_PUMP  = 4'h7,
        FN_TOTAL = 4'h8,
        FN_TIMED = 4'h9
    } relay_func_t;
    // per-relay failsafe reaction
    typedef enum logic [1:0] {
        FSA_FOLLOW = 2'h0,
        FSA_HOLD   = 2'h1,
        FSA_COILOFF = 2'h2,
        FSA_COILON = 2'h3
    } fs_action_t;
    // failsafe material level
    typedef enum logic [1:0] {
        FSL_HOLD = 2'h0,
        FSL_HIGH = 2'h1,
        FSL_LOW  = 2'h2
    } fs_level_t;
    // ==========================================
    typedef struct packed {
        relay_func_t        func;
        logic               inv;
        fs_action_t         fsa;
        logic signed [15:0] on_sp;
        logic signed [15:0] off_sp;
    } relay_cfg_t;
    typedef struct packed {
        logic [31:0]          prdata;
        logic                 pready;
        logic                 pslverr;
        logic                 prog;
        fs_level_t            fs_level;
        logic                 test_en;
        logic [2:0]           test_sel;
        logic [15:0]          fs_ms;
        logic [15:0]          span;
        relay_cfg_t [5:0]     cfg;
        logic [15:0]          ms_cnt;
        logic [15:0]          fs_cnt;
        logic                 fs_exp;
        logic [5:0]           act;
        logic [5:0]           coil;
        logic [5:0][15:0]     tcnt;
        logic [5:0]           tphase;
    } relay_state_t;
endpackage : relay_pkg

// ===== hdl/relay_ctrl.sv
// relay decision logic: setpoints, failsafe, program mode, coil drive
// assumes measurements and echo flags come from logic on pclk
//
// The implementer's own choices: the APB register port and the register addresses.
`include "relay_consts.svh"

// Functional notes
// [R1] in-bounds alarm active inside setpoint zone
// [R2] out-of-bounds alarm active outside zone
// [R3] rate alarm on at ON, off at OFF
// [R4] software gives emptying setpoints as negatives
// [R5] temperature alarm switches with setpoint hysteresis
// [R6] loss of echo on expiry, echo clears
// [R7] pump down/up switch at ON and OFF
// [R8] totalizer relay pulses 200 ms closures
// [R9] ON above OFF means high/down direction
// [R10] software keeps ON and OFF unequal
// [R11] bounds alarms use 2 percent span hysteresis
// [R12] failsafe level drives alarms, pumps normal
// [R13] program mode stops pumps, alarms hold
// [R14] alarm relay coil energized when quiet
// [R15] control relay coil energized when active
// [R16] invert setting reverses output sense
// [R17] per-relay failsafe: follow, hold, off, on
// [R18] wiring test forces chosen relay active
// [R19] timed relay: interval then duration
// [R20] level alarm switches with setpoint hysteresis
// [R21] failsafe timer runs during error
// [R22] reached means equal or past; hold between
module relay_ctrl #(
    parameter int MS_CYCLES = `MS_CYC
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic signed [15:0] level,
    input  wire logic signed [15:0] rate_of_change,
    input  wire logic signed [15:0] temperature,
    input  wire logic               echo_valid,
    input  wire logic               echo_error,
    input  wire logic [5:0]         count_pulse,
    output logic      [5:0]         relay_coil
);
    relay_pkg::relay_state_t s, n;
    logic [5:0] norm;
    logic [5:0] high_dir;
    logic       tick;

    // ==========================================
    // millisecond tick shared by timers
    assign tick = (s.ms_cnt == 16'(MS_CYCLES - 1));

    // ==========================================
    // per-relay setpoint evaluation
    genvar g;
    for (g = 0; g < `NUM_RELAYS; g++) begin : g_rly
        relay_pkg::relay_cfg_t c;
        logic signed [15:0] v;
        logic signed [16:0] lo, hi, hy;
        logic               hit_on, hit_off;
        assign c = s.cfg[g];
        assign high_dir[g] = (c.on_sp > c.off_sp); // [R9]
        // pick the process value for this function
        always_comb begin
            unique case (c.func)
                relay_pkg::FN_RATE: v = rate_of_change;
                relay_pkg::FN_TEMP: v = temperature;
                default:            v = level;
            endcase
        end
        // reached means equal or passed, in either direction
        assign hit_on  = high_dir[g] ? (v >= c.on_sp)
                                     : (v <= c.on_sp);  // [R22]
        assign hit_off = high_dir[g] ? (v <= c.off_sp)
                                     : (v >= c.off_sp); // [R22]
        // fixed band around each bound zone edge
        assign hy = 17'(($signed({1'b0, s.span}) * `HYS_PCT) / 100); // [R11]
        assign lo = high_dir[g] ? 17'(c.off_sp) : 17'(c.on_sp);
        assign hi = high_dir[g] ? 17'(c.on_sp) : 17'(c.off_sp);
        // next activity in normal running
        always_comb begin
            norm[g] = s.act[g];
            unique case (c.func)
                relay_pkg::FN_LVL, relay_pkg::FN_RATE,
                relay_pkg::FN_TEMP, relay_pkg::FN_PUMP: begin
                    if (hit_on)                     // [R20] [R3] [R5] [R7]
                        norm[g] = 1'b1;
                    else if (hit_off)
                        norm[g] = 1'b0;             // [R22]
                end
                relay_pkg::FN_INB: begin
                    if (17'(v) >= lo + hy && 17'(v) <= hi - hy)
                        norm[g] = 1'b1;             // [R1]
                    else if (17'(v) < lo - hy || 17'(v) > hi + hy)
                        norm[g] = 1'b0;             // [R1] [R11]
                end
                relay_pkg::FN_OOB: begin
                    if (17'(v) < lo - hy || 17'(v) > hi + hy)
                        norm[g] = 1'b1;             // [R2]
                    else if (17'(v) >= lo + hy && 17'(v) <= hi - hy)
                        norm[g] = 1'b0;             // [R2] [R11]
                end
                relay_pkg::FN_LOE:   norm[g] = s.fs_exp;       // [R6]
                relay_pkg::FN_TOTAL: norm[g] = (s.tcnt[g] != 16'h0000);
                relay_pkg::FN_TIMED: norm[g] = s.tphase[g];    // [R19]
                default:             norm[g] = 1'b0;
            endcase
        end
    end

    // ==========================================
    // next state: apb slave, timers, relay outputs
    always_comb begin
        logic       wr, alarm, ctl, fs, tst;
        logic [5:0] ri;
        logic [3:0] ro;
        n        = s;
        wr       = psel && penable && s.pready && pwrite;
        ri       = 6'(paddr[7:4] - 4'h2);
        ro       = paddr[3:0];
        alarm    = 1'b0;
        ctl      = 1'b0;
        fs       = 1'b0;
        tst      = 1'b0;
        n.pready = 1'b0;
        // setup cycle: no wait state, answer with data in the access cycle
        if (psel && !penable) begin
            n.pready  = 1'b1;
            n.pslverr = 1'b0;
            n.prdata  = 32'h0000_0000;
            unique case (paddr)
                `OFF_CTRL:     n.prdata = {25'h0, s.test_sel, s.test_en,
                                           s.fs_level, s.prog};
                `OFF_FS_TIMER: n.prdata = {16'h0, s.fs_ms};
                `OFF_STATUS:   n.prdata = {19'h0, s.fs_exp, s.act, s.coil};
                `OFF_SPAN:     n.prdata = {16'h0, s.span};
                default: begin
                    if (paddr >= `OFF_RLY_BASE && ri < 6'(`NUM_RELAYS)
                        && ro == `RLY_CFG)
                        n.prdata = {25'h0, s.cfg[ri].fsa, s.cfg[ri].inv,
                                    s.cfg[ri].func};
                    else if (paddr >= `OFF_RLY_BASE
                             && ri < 6'(`NUM_RELAYS) && ro == `RLY_ON)
                        n.prdata = {16'h0, s.cfg[ri].on_sp};
                    else if (paddr >= `OFF_RLY_BASE
                             && ri < 6'(`NUM_RELAYS) && ro == `RLY_OFF)
                        n.prdata = {16'h0, s.cfg[ri].off_sp};
                    else
                        n.pslverr = 1'b1;
                end
            endcase
        end
        // writes land only at the completing edge; status is read-only
        if (wr && !s.pslverr) begin
            unique case (paddr)
                `OFF_CTRL: begin
                    n.prog     = pwdata[`CTRL_PROG];
                    n.fs_level = relay_pkg::fs_level_t'(
                                     pwdata[`CTRL_FSL_LO +: 2]);
                    n.test_en  = pwdata[`CTRL_TEST_EN];
                    n.test_sel = pwdata[`CTRL_TSEL_LO +: 3];
                end
                `OFF_FS_TIMER: n.fs_ms = pwdata[15:0];
                `OFF_SPAN:     n.span  = pwdata[15:0];
                `OFF_STATUS:   n.fs_ms = s.fs_ms;
                default: begin
                    if (ro == `RLY_CFG) begin
                        n.cfg[ri].func = relay_pkg::relay_func_t'(
                                             pwdata[3:0]);
                        n.cfg[ri].inv  = pwdata[`CFG_INV];
                        n.cfg[ri].fsa  = relay_pkg::fs_action_t'(
                                             pwdata[`CFG_FSA_LO +: 2]);
                    end else if (ro == `RLY_ON)
                        n.cfg[ri].on_sp = pwdata[15:0];
                    else
                        n.cfg[ri].off_sp = pwdata[15:0];
                end
            endcase
        end
        // millisecond prescaler
        n.ms_cnt = tick ? 16'h0000 : s.ms_cnt + 16'h0001;
        // failsafe timer: a valid echo wins and restarts it
        if (echo_valid) begin
            n.fs_cnt = 16'h0000;                    // [R6]
            n.fs_exp = 1'b0;                        // [R6]
        end else if (echo_error && !s.fs_exp && tick) begin
            if (s.fs_cnt + 16'h0001 >= s.fs_ms)
                n.fs_exp = 1'b1;                    // [R21]
            else
                n.fs_cnt = s.fs_cnt + 16'h0001;     // [R21]
        end
        // relay outcome, one pass per relay
        for (int i = 0; i < `NUM_RELAYS; i++) begin
            // pulse and interval timers run in ms steps
            if (s.cfg[i].func == relay_pkg::FN_TOTAL) begin
                if (s.tcnt[i] == 16'h0000 && count_pulse[i])
                    n.tcnt[i] = `PULSE_MS;          // [R8]
                else if (s.tcnt[i] != 16'h0000 && tick)
                    n.tcnt[i] = s.tcnt[i] - 16'h0001;
            end else if (s.cfg[i].func == relay_pkg::FN_TIMED) begin
                if (tick) begin
                    if (s.tcnt[i] + 16'h0001 >= (s.tphase[i]
                        ? s.cfg[i].off_sp : s.cfg[i].on_sp)) begin
                        n.tcnt[i]   = 16'h0000;     // [R19]
                        n.tphase[i] = !s.tphase[i]; // [R19]
                    end else
                        n.tcnt[i] = s.tcnt[i] + 16'h0001;
                end
            end else begin
                n.tcnt[i]   = 16'h0000;
                n.tphase[i] = 1'b0;
            end
            unique case (s.cfg[i].func)
                relay_pkg::FN_LVL, relay_pkg::FN_INB, relay_pkg::FN_OOB,
                relay_pkg::FN_RATE, relay_pkg::FN_TEMP,
                relay_pkg::FN_LOE:  alarm = 1'b1;
                default:            alarm = 1'b0;
            endcase
            ctl = (s.cfg[i].func != relay_pkg::FN_OFF) && !alarm;
            tst = s.test_en && (s.test_sel == 3'(i));
            fs  = s.fs_exp && (s.cfg[i].func != relay_pkg::FN_LOE);
            n.act[i] = norm[i];
            // failsafe: alarms follow the material level, pumps carry on
            if (fs && alarm && s.cfg[i].fsa == relay_pkg::FSA_FOLLOW) begin
                unique case (s.fs_level)
                    relay_pkg::FSL_HIGH: n.act[i] = high_dir[i];  // [R12]
                    relay_pkg::FSL_LOW:  n.act[i] = !high_dir[i]; // [R12]
                    default:             n.act[i] = s.act[i];     // [R12]
                endcase
            end else if (fs && s.cfg[i].fsa == relay_pkg::FSA_HOLD)
                n.act[i] = s.act[i];                              // [R17]
            // program mode parks pumps and holds alarms at their last state
            if (s.prog)
                n.act[i] = alarm ? s.act[i] : 1'b0;               // [R13]
            if (tst)
                n.act[i] = 1'b1;                                  // [R18]
            // coil sense: alarms idle energized, controls idle off
            if (alarm)
                n.coil[i] = !n.act[i];                            // [R14]
            else
                n.coil[i] = ctl && n.act[i];                      // [R15]
            n.coil[i] = n.coil[i] ^ s.cfg[i].inv;                 // [R16]
            // forced coil states bypass the sense, except under test or in program mode
            if (fs && !tst && !s.prog
                && s.cfg[i].fsa == relay_pkg::FSA_COILOFF)
                n.coil[i] = 1'b0;                                 // [R17]
            else if (fs && !tst && !s.prog
                     && s.cfg[i].fsa == relay_pkg::FSA_COILON)
                n.coil[i] = 1'b1;                                 // [R17]
        end
    end

    // ==========================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s          <= '0;
            s.fs_ms    <= `FS_MS_RST;
            s.span     <= `SPAN_RST;
        end else begin
            s <= n;
        end
    end

    assign prdata     = s.prdata;
    assign pready     = s.pready;
    assign pslverr    = s.pslverr;
    assign relay_coil = s.coil;

    // ==========================================
    // checks on the relays each scenario sets up, and the shared logic
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic quiet0;
    assign quiet0 = !s.fs_exp && !s.prog && !s.test_en && !s.cfg[0].inv;
    logic quiet2;
    assign quiet2 = !s.fs_exp && !s.prog && !s.test_en && !s.cfg[2].inv;

    a_apb_wait_state: assert property (
        psel && !penable |=> pready)
        else $error("no ready after setup cycle");
    a_lvl_hyst_on: assert property ( // [R20]
        quiet2 && s.cfg[2].func == relay_pkg::FN_LVL
        && s.cfg[2].on_sp > s.cfg[2].off_sp && level >= s.cfg[2].on_sp
        |=> s.act[2] && !relay_coil[2])
        else $error("high level alarm not raised");
    a_lvl_hyst_hold: assert property ( // [R22]
        quiet2 && s.cfg[2].func == relay_pkg::FN_LVL
        && level < s.cfg[2].on_sp && level > s.cfg[2].off_sp
        |=> s.act[2] == $past(s.act[2]))
        else $error("alarm changed inside dead band");
    a_pump_coil_on: assert property ( // [R15]
        quiet0 && s.cfg[0].func == relay_pkg::FN_PUMP
        |=> relay_coil[0] == s.act[0])
        else $error("pump coil sense wrong");
    a_pump_prog_off: assert property ( // [R13]
        s.prog && !s.test_en && !s.fs_exp && !s.cfg[0].inv
        && s.cfg[0].func == relay_pkg::FN_PUMP |=> !relay_coil[0])
        else $error("pump running in program mode");
    a_invert_sense: assert property ( // [R16]
        !s.fs_exp && !s.test_en && s.cfg[3].inv
        && s.cfg[3].func == relay_pkg::FN_LVL
        |=> relay_coil[3] == s.act[3])
        else $error("inverted coil sense wrong");
    a_echo_clears: assert property ( // [R6]
        echo_valid |=> !s.fs_exp && s.fs_cnt == 16'h0000)
        else $error("valid echo left failsafe set");
    a_loe_follows: assert property ( // [R6]
        s.fs_exp && !s.prog && !s.test_en
        && s.cfg[4].func == relay_pkg::FN_LOE |=> s.act[4])
        else $error("loss of echo not raised");
    a_pulse_load: assert property ( // [R8]
        s.cfg[5].func == relay_pkg::FN_TOTAL && s.tcnt[5] == 16'h0000
        && count_pulse[5] |=> s.tcnt[5] == `PULSE_MS ##1 s.tcnt[5] != 0)
        else $error("totalizer pulse not started");
    a_fs_coil_on: assert property ( // [R17]
        s.fs_exp && !s.prog && !s.test_en
        && s.cfg[1].func == relay_pkg::FN_PUMP
        && s.cfg[1].fsa == relay_pkg::FSA_COILON |=> relay_coil[1])
        else $error("failsafe energize ignored");
    a_fs_alarm_high: assert property ( // [R12]
        s.fs_exp && !s.prog && !s.test_en
        && s.cfg[2].func == relay_pkg::FN_LVL
        && s.cfg[2].fsa == relay_pkg::FSA_FOLLOW
        && s.fs_level == relay_pkg::FSL_HIGH
        |=> s.act[2] == $past(s.cfg[2].on_sp > s.cfg[2].off_sp))
        else $error("failsafe high ignored by alarm");
    a_test_force: assert property ( // [R18]
        s.test_en && s.test_sel == 3'h1 |=> s.act[1])
        else $error("wiring test did not force relay");

    c_fs_expire: cover property (!s.fs_exp ##1 s.fs_exp);
    c_pump_cycle: cover property (
        s.cfg[0].func == relay_pkg::FN_PUMP && $rose(s.act[0]));
    c_err_read: cover property (pready && pslverr);
    c_timed_on: cover property ($rose(s.tphase[0]));
endmodule : relay_ctrl

// ===== tb/relay_coil_bank.sv
// relay coil bank on the far side of the coil drivers
// assumes relay_coil is registered on pclk; lengths counted in cycles
module relay_coil_bank (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [5:0]       relay_coil,
    output logic      [5:0][15:0] last_len
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0][15:0] run_len;
    // ==========================================
    // closure timing
    // a coil is a passive load, so this side never pushes back
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_len  <= '0;
            last_len <= '0;
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (relay_coil[i]) begin
                    run_len[i] <= run_len[i] + 16'h0001;
                end else if (run_len[i] != 16'h0000) begin
                    last_len[i] <= run_len[i];
                    run_len[i]  <= 16'h0000;
                end
            end
        end
    end
endmodule : relay_coil_bank

// ===== tb/relay_ctrl_tb.sv
// self-checking bench for relay_ctrl, driven over apb
// assumes hdl/ on the include path; one ms shortened to 10 cycles
`include "relay_consts.svh"
module relay_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MSC = 10;
    logic               pclk, presetn, psel, penable, pwrite;
    logic        [7:0]  paddr;
    logic        [31:0] pwdata, prdata, rd;
    logic               pready, pslverr, err;
    logic signed [15:0] level, rate_of_change, temperature;
    logic               echo_valid, echo_error;
    logic        [5:0]  count_pulse, relay_coil;
    logic [5:0][15:0]   last_len;
    int                 n_fail, n_checks;
    int lv [9] = '{50, 100, 300, 190, 170, 20, 50, 99, 100};
    logic [5:0] ex [9] = '{6'h14, 6'h11, 6'h21, 6'h21, 6'h11,
                           6'h1E, 6'h1E, 6'h1E, 6'h11};

    relay_ctrl #(.MS_CYCLES(MSC)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .level(level),
        .rate_of_change(rate_of_change), .temperature(temperature),
        .echo_valid(echo_valid), .echo_error(echo_error),
        .count_pulse(count_pulse), .relay_coil(relay_coil));
    relay_coil_bank coils (.pclk(pclk), .presetn(presetn),
        .relay_coil(relay_coil), .last_len(last_len));

    always #10 pclk = ~pclk;

    // ==========================================
    // bus and compare tasks
    task automatic step(input int n);
        repeat (n) @(posedge pclk);
    endtask : step
    // request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            n_fail++;
            $display("MISMATCH at %0t: no pready", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, msg, got,
                     exp);
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd & m, exp, "read");
    endtask : rdchk
    // coils read mid-cycle, away from the edge that moves them
    task automatic coil(input logic [5:0] m, input logic [5:0] exp);
        @(negedge pclk);
        chk(32'(relay_coil & m), 32'(exp), "coil");
    endtask : coil
    // on and off always differ, as the relay needs; off goes first so
    // the half-written pair leaves the relay idle, not latched on
    task automatic cfg(input int i, input logic [31:0] c,
                       input logic signed [15:0] on, off);
        apb(1'b1, 8'(32 + 16 * i), c);
        apb(1'b1, 8'(40 + 16 * i), 32'(off));
        apb(1'b1, 8'(36 + 16 * i), 32'(on));
    endtask : cfg
    task automatic pv(input int l, r, t);
        @(posedge pclk);
        level <= 16'(l);
        rate_of_change <= 16'(r);
        temperature <= 16'(t);
        step(2);
    endtask : pv
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    // ==========================================
    // watchdog, far beyond the few thousand cycles the tests need
    initial begin
        step(20000);
        n_fail++;
        report_and_stop();
    end

    // ==========================================
    // test sequence
    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = '0; pwdata = '0; level = 16'sd50; rate_of_change = '0;
        temperature = '0; echo_valid = 0; echo_error = 0; count_pulse = '0;
        n_fail = 0; n_checks = 0; rd = '0; err = 0;
        step(20);
        presetn <= 1'b1;
        coil(6'h3F, 6'h00);
        rdchk(`OFF_FS_TIMER, 32'h0000_FFFF, 32'(`FS_MS_RST));
        rdchk(`OFF_SPAN, 32'h0000_FFFF, 32'(`SPAN_RST));
        apb(1'b0, 8'h14, 32'h0000_0000);
        chk(32'(err), 32'h0000_0001, "unmapped");
        $display("test reset done");
        // relays 0,1 pumps; 2,3 level alarms (3 inverted); 4,5 zones
        cfg(0, 32'(relay_pkg::FN_PUMP), 100, 20);
        cfg(1, 32'(relay_pkg::FN_PUMP) | 32'h0000_0060, 20, 100);
        cfg(2, 32'(relay_pkg::FN_LVL), 100, 20);
        cfg(3, 32'(relay_pkg::FN_LVL) | 32'h0000_0010, 20, 100);
        cfg(4, 32'(relay_pkg::FN_INB), 200, 400);
        cfg(5, 32'(relay_pkg::FN_OOB), 200, 400);
        for (int k = 0; k < 9; k++) begin
            pv(lv[k], 0, 0);
            coil(6'h3F, ex[k]);
            if (k == 1) begin
                rdchk(`OFF_STATUS, 32'h0000_0FFF, 32'h0000_0951);
            end
        end
        $display("test level done");
        cfg(2, 32'(relay_pkg::FN_RATE), 50, 10);
        cfg(3, 32'(relay_pkg::FN_TEMP), 40, 30);
        pv(100, 0, 0);
        coil(6'h0C, 6'h0C);
        pv(100, 50, 40);
        coil(6'h0C, 6'h00);
        pv(100, 30, 35);
        coil(6'h0C, 6'h00);
        pv(100, 10, 30);
        coil(6'h0C, 6'h0C);
        // emptying alarm: both setpoints below zero
        cfg(2, 32'(relay_pkg::FN_RATE), -50, -10);
        pv(100, -50, 30);
        coil(6'h04, 6'h00);
        pv(100, -10, 30);
        coil(6'h04, 6'h04);
        $display("test rate done");
        // failsafe high after 3 ms of echo error
        cfg(2, 32'(relay_pkg::FN_LVL), 100, 20);
        cfg(4, 32'(relay_pkg::FN_LOE), 1, 0);
        apb(1'b1, `OFF_FS_TIMER, 32'h0000_0003);
        apb(1'b1, `OFF_CTRL, 32'h0000_0002);
        pv(50, 10, 30);
        // relay 2 keeps the alarm it took at level 100
        coil(6'h17, 6'h11);
        @(posedge pclk);
        echo_error <= 1'b1;
        step(15);
        rdchk(`OFF_STATUS, 32'h0000_1000, 32'h0000_0000);
        step(25);
        rdchk(`OFF_STATUS, 32'h0000_1000, 32'h0000_1000);
        coil(6'h17, 6'h03);
        @(posedge pclk);
        echo_error <= 1'b0;
        echo_valid <= 1'b1;
        step(3);
        coil(6'h13, 6'h11);
        rdchk(`OFF_STATUS, 32'h0000_1000, 32'h0000_0000);
        echo_valid <= 1'b0;
        $display("test failsafe done");
        pv(100, 10, 30);
        coil(6'h05, 6'h01);
        apb(1'b1, `OFF_CTRL, 32'h0000_0001);
        step(2);
        coil(6'h05, 6'h00);
        apb(1'b1, `OFF_CTRL, 32'h0000_0018);
        step(2);
        coil(6'h02, 6'h02);
        apb(1'b1, `OFF_CTRL, 32'h0000_0000);
        $display("test modes done");
        cfg(5, 32'(relay_pkg::FN_TOTAL), 1, 0);
        step(3);
        coil(6'h20, 6'h00);
        @(posedge pclk);
        count_pulse <= 6'h20;
        @(posedge pclk);
        count_pulse <= 6'h00;
        step(20);
        coil(6'h20, 6'h20);
        step(2100);
        chk(32'(last_len[5] >= 16'(`PULSE_MS * MSC - MSC) &&
                last_len[5] <= 16'(`PULSE_MS * MSC + MSC)),
            32'h0000_0001, "pulse");
        coil(6'h20, 6'h00);
        $display("test totalizer done");
        // interval 3 ms off, duration 2 ms on
        cfg(0, 32'(relay_pkg::FN_TIMED), 3, 2);
        step(120);
        chk(32'(last_len[0]), 32'(2 * MSC), "timed");
        $display("test timed done");
        report_and_stop();
    end
endmodule : relay_ctrl_tb
